// file: watchdog_and_reset_control.sv
// Watchdog timer, key-checked soft resets and low-voltage reset supervision
// Assumes the low-speed RC clock arrives as a level synchronous to clk
//
// What this block does
// - Watchdog counts low-speed RC clock edges, divided by 2^8 to 2^18.
// - Timeout select codes pick exponents 8,10,12,14,15,16,17,18.
// - Enable key 10101 disables the watchdog, 01010 enables it.
// - Other enable key values reset after the soft delay and flag it.
// - Enable key holds 01010 after power-on, so watchdog runs.
// - Watchdog key flag set by hardware, cleared only by software zero.
// - Overflow in normal running resets the device and sets expired flag.
// - Overflow in sleep or idle sets expired flag, clears only PC and SP.
// - Counter clears on bad enable key, clear instruction or halt.
// - Integrity key other than 55h or AAh resets after soft delay.
// - Integrity key holds 01010101 after power-on.
// - Integrity key reset sets its own sticky flag, software-cleared.
// - All resets restore the integrity key except sleep timeout.
// - Upper four cause flag bits read as zero.
// - Low-voltage reset disabled automatically in sleep and idle.
// - Low-voltage reset only when the dip outlasts the filter time.
// - Undefined level code resets after soft delay, sets its flag.
// - Level select holds 01100110 after power-on.
// - Power-on clears the PC and presets all port registers high.
// - Level codes 55h,33h,99h thresholds; AAh reserved; F0h disabled.
// - Genuine low-voltage reset keeps level select; bad code restores it.
// - Sleep timeout sets expired and power-down; normal leaves power-down.
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`include "watchdog_cfg.svh"

module watchdog_and_reset_control (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [4:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  input  wire logic                    low_speed_rc_clock,
  input  wire logic                    lowvolt_detect,
  input  wire watchdog_pkg::cpu_event_t cpu_event,
  output watchdog_pkg::reset_req_t     reset_req
);
  import watchdog_pkg::*;

  //////////////////////////////////////////////////////////////////////////

  logic [7:0]   watchdog_control_r;
  logic [7:0]   reset_integrity_key_r;
  logic [7:0]   lowvolt_config_r;
  cause_flags_t reset_cause_flags_r;
  logic         watchdog_expired_flag_r;
  logic         powerdown_flag_r;
  logic [17:0]  wdt_cnt_r;
  logic         rc_prev_r;
  logic         waitrequest_r;
  logic [31:0]  readdata_r;
  logic [31:0]  readdata_nxt;
  reset_req_t   reset_req_r;

  logic [4:0]   watchdog_enable_key;
  logic [2:0]   timeout_select;
  logic [17:0]  wdt_limit;
  logic         rc_rise;
  logic         wdt_enabled;
  logic         wdt_key_bad;
  logic         integ_key_bad;
  logic         lv_level_valid;
  logic         lv_undefined;
  logic         lv_active;
  logic         wdt_key_fire;
  logic         integ_fire;
  logic         lv_sel_fire;
  logic         lv_fire;
  logic         wdt_overflow;
  logic         wdt_normal_reset;
  logic         sleep_timeout;
  logic         full_reset;
  logic         bus_accept;
  logic         low_write;

  //////////////////////////////////////////////////////////////////////////
  // Key and level decode

  assign watchdog_enable_key = watchdog_control_r[`WDT_KEY_MSB:`WDT_KEY_LSB];
  assign timeout_select      = watchdog_control_r[`WDT_SEL_MSB:`WDT_SEL_LSB];
  assign wdt_enabled         = watchdog_enable_key == `WDT_KEY_ENABLE;
  assign wdt_key_bad         = watchdog_enable_key != `WDT_KEY_ENABLE &&
                               watchdog_enable_key != `WDT_KEY_DISABLE;
  assign integ_key_bad       = reset_integrity_key_r != `INTEG_KEY_A &&
                               reset_integrity_key_r != `INTEG_KEY_B;

  // Power-on code counts as a defined level, else resets would never stop
  assign lv_level_valid = lowvolt_config_r == `LV_LEVEL_1V90 ||
                          lowvolt_config_r == `LV_LEVEL_2V55 ||
                          lowvolt_config_r == `LV_LEVEL_3V15 ||
                          lowvolt_config_r == `LOWVOLT_CONFIG_POR;
  assign lv_undefined   = !lv_level_valid &&
                          lowvolt_config_r != `LV_LEVEL_RESERVED &&
                          lowvolt_config_r != `LV_LEVEL_OFF;
  // Reserved and off codes arm nothing; sleep and idle mask the detector
  assign lv_active      = lv_level_valid && !cpu_event.sleep_idle &&
                          lowvolt_detect;

  //////////////////////////////////////////////////////////////////////////
  // Timeout limit: one less than two to the selected exponent

  always_comb begin
    case (timeout_select)
      3'h0:    wdt_limit = 18'h000FF;
      3'h1:    wdt_limit = 18'h003FF;
      3'h2:    wdt_limit = 18'h00FFF;
      3'h3:    wdt_limit = 18'h03FFF;
      3'h4:    wdt_limit = 18'h07FFF;
      3'h5:    wdt_limit = 18'h0FFFF;
      3'h6:    wdt_limit = 18'h1FFFF;
      default: wdt_limit = 18'h3FFFF;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset sources

  assign rc_rise          = low_speed_rc_clock && !rc_prev_r;
  assign wdt_overflow     = wdt_enabled && rc_rise &&
                            wdt_cnt_r == wdt_limit;
  assign wdt_normal_reset = wdt_overflow && !cpu_event.sleep_idle;
  assign sleep_timeout    = wdt_overflow && cpu_event.sleep_idle;
  assign full_reset       = wdt_key_fire || integ_fire || lv_sel_fire ||
                            lv_fire || wdt_normal_reset;

  // A full reset from one source cancels the waits of all others
  delay_qualifier #(
    .COUNT (16'(`SOFT_RESET_CYCLES))
  ) u_wdt_key_delay (
    .clk   (clk),
    .rst   (rst),
    .clear (full_reset),
    .cond  (wdt_key_bad),
    .fire  (wdt_key_fire)
  );

  delay_qualifier #(
    .COUNT (16'(`SOFT_RESET_CYCLES))
  ) u_integ_delay (
    .clk   (clk),
    .rst   (rst),
    .clear (full_reset),
    .cond  (integ_key_bad),
    .fire  (integ_fire)
  );

  delay_qualifier #(
    .COUNT (16'(`SOFT_RESET_CYCLES))
  ) u_lv_sel_delay (
    .clk   (clk),
    .rst   (rst),
    .clear (full_reset),
    .cond  (lv_undefined),
    .fire  (lv_sel_fire)
  );

  // One cycle beyond the filter time, since the dip must outlast it
  delay_qualifier #(
    .COUNT (16'(`LV_FILTER_CYCLES + 1))
  ) u_lv_filter (
    .clk   (clk),
    .rst   (rst),
    .clear (full_reset),
    .cond  (lv_active),
    .fire  (lv_fire)
  );

  //////////////////////////////////////////////////////////////////////////
  // Watchdog counter

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_prev_r <= 1'b0;
    end else begin
      rc_prev_r <= low_speed_rc_clock;
    end
  end

  // Clearing on every full reset too, so the count begins afresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_cnt_r <= 18'h00000;
    end else if (wdt_key_fire || cpu_event.clear_watchdog_instr ||
                 cpu_event.halt_instr || full_reset) begin
      wdt_cnt_r <= 18'h00000;
    end else if (!wdt_enabled) begin
      wdt_cnt_r <= 18'h00000;
    end else if (rc_rise) begin
      wdt_cnt_r <= (wdt_cnt_r == wdt_limit) ? 18'h00000 :
                   18'(wdt_cnt_r + 18'h00001);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then a single ready cycle

  assign bus_accept = (read || write) && !waitrequest_r;
  assign low_write  = write && !waitrequest_r && byteenable[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else begin
      waitrequest_r <= !((read || write) && waitrequest_r);
    end
  end

  always_comb begin
    readdata_nxt = 32'h00000000;
    case (address)
      `WATCHDOG_CONTROL_OFS: readdata_nxt[7:0] = watchdog_control_r;
      `RESET_CAUSE_OFS:      readdata_nxt[3:0] = reset_cause_flags_r;
      `INTEGRITY_KEY_OFS:    readdata_nxt[7:0] = reset_integrity_key_r;
      `LOWVOLT_CONFIG_OFS:   readdata_nxt[7:0] = lowvolt_config_r;
      `RUN_STATUS_OFS: begin
        readdata_nxt[`STAT_EXPIRED_BIT] = watchdog_expired_flag_r;
        readdata_nxt[`STAT_PDOWN_BIT]   = powerdown_flag_r;
      end
      default:               readdata_nxt = 32'h00000000;
    endcase
  end

  // Captured while the wait cycle runs, so data stand at the ready edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_r <= 32'h00000000;
    end else if (read && waitrequest_r) begin
      readdata_r <= readdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  // Key resets win over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_POR;
    end else if (full_reset) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_POR;
    end else if (low_write && address == `WATCHDOG_CONTROL_OFS) begin
      watchdog_control_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_integrity_key_r <= `INTEGRITY_KEY_POR;
    end else if (full_reset) begin
      reset_integrity_key_r <= `INTEGRITY_KEY_POR;
    end else if (low_write && address == `INTEGRITY_KEY_OFS) begin
      reset_integrity_key_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowvolt_config_r <= `LOWVOLT_CONFIG_POR;
    end else if (wdt_key_fire || integ_fire || lv_sel_fire ||
                 wdt_normal_reset) begin
      lowvolt_config_r <= `LOWVOLT_CONFIG_POR;
    end else if (!full_reset && low_write &&
                 address == `LOWVOLT_CONFIG_OFS) begin
      lowvolt_config_r <= writedata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky cause flags: set beats a software clear; writing one is ignored

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_cause_flags_r <= `RESET_CAUSE_POR;
    end else begin
      if (wdt_key_fire) begin
        reset_cause_flags_r.watchdog_key_reset_flag <= 1'b1;
      end else if (low_write && address == `RESET_CAUSE_OFS &&
                   !writedata[`CAUSE_WDT_KEY_BIT]) begin
        reset_cause_flags_r.watchdog_key_reset_flag <= 1'b0;
      end
      if (lv_sel_fire) begin
        reset_cause_flags_r.level_select_reset_flag <= 1'b1;
      end else if (low_write && address == `RESET_CAUSE_OFS &&
                   !writedata[`CAUSE_LV_SEL_BIT]) begin
        reset_cause_flags_r.level_select_reset_flag <= 1'b0;
      end
      if (lv_fire) begin
        reset_cause_flags_r.lowvolt_reset_flag <= 1'b1;
      end else if (low_write && address == `RESET_CAUSE_OFS &&
                   !writedata[`CAUSE_LV_BIT]) begin
        reset_cause_flags_r.lowvolt_reset_flag <= 1'b0;
      end
      if (integ_fire) begin
        reset_cause_flags_r.integrity_key_reset_flag <= 1'b1;
      end else if (low_write && address == `RESET_CAUSE_OFS &&
                   !writedata[`CAUSE_INTEG_BIT]) begin
        reset_cause_flags_r.integrity_key_reset_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Expired and power-down flags

  // Halt and clear instruction drop the flag, but an overflow wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_expired_flag_r <= 1'b0;
    end else if (wdt_overflow) begin
      watchdog_expired_flag_r <= 1'b1;
    end else if (cpu_event.halt_instr ||
                 cpu_event.clear_watchdog_instr) begin
      watchdog_expired_flag_r <= 1'b0;
    end
  end

  // Normal-mode resets leave power-down untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerdown_flag_r <= 1'b0;
    end else if (sleep_timeout || cpu_event.halt_instr) begin
      powerdown_flag_r <= 1'b1;
    end else if (cpu_event.clear_watchdog_instr) begin
      powerdown_flag_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset requests to the core

  // Held high through power-on so the PC is zero and pins are inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_req_r.device_reset <= 1'b1;
      reset_req_r.pc_sp_clear  <= 1'b1;
      reset_req_r.ports_preset <= 1'b1;
    end else begin
      reset_req_r.device_reset <= full_reset;
      reset_req_r.pc_sp_clear  <= full_reset || sleep_timeout;
      reset_req_r.ports_preset <= full_reset;
    end
  end

  assign reset_req   = reset_req_r;
  assign readdata    = readdata_r;
  assign waitrequest = waitrequest_r;

endmodule

// file: watchdog_cfg.svh
// Offsets, field positions, reset values, key codes and timing counts
// Assumes a 100 MHz system clock and byte addresses on a 32-bit bus
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

`define CLK_PERIOD_NS        10
`define SOFT_RESET_DELAY_NS  1000
`define SOFT_RESET_CYCLES    ((`SOFT_RESET_DELAY_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define LV_FILTER_TIME_NS    1000
`define LV_FILTER_CYCLES     ((`LV_FILTER_TIME_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)

`define WATCHDOG_CONTROL_OFS  5'h00
`define RESET_CAUSE_OFS       5'h04
`define INTEGRITY_KEY_OFS     5'h08
`define LOWVOLT_CONFIG_OFS    5'h0C
`define RUN_STATUS_OFS        5'h10

`define WDT_KEY_MSB          7
`define WDT_KEY_LSB          3
`define WDT_SEL_MSB          2
`define WDT_SEL_LSB          0
`define CAUSE_WDT_KEY_BIT    0
`define CAUSE_LV_SEL_BIT     1
`define CAUSE_LV_BIT         2
`define CAUSE_INTEG_BIT      3
`define STAT_EXPIRED_BIT     0
`define STAT_PDOWN_BIT       1

`define WATCHDOG_CONTROL_POR 8'h53
`define INTEGRITY_KEY_POR    8'h55
`define LOWVOLT_CONFIG_POR   8'h66
`define RESET_CAUSE_POR      4'h0

`define WDT_KEY_DISABLE      5'h15
`define WDT_KEY_ENABLE       5'h0A
`define INTEG_KEY_A          8'h55
`define INTEG_KEY_B          8'hAA
`define LV_LEVEL_1V90        8'h55
`define LV_LEVEL_2V55        8'h33
`define LV_LEVEL_3V15        8'h99
`define LV_LEVEL_RESERVED    8'hAA
`define LV_LEVEL_OFF         8'hF0

`endif

// file: watchdog_pkg.sv
// Types shared by the watchdog and reset supervision block
// Assumes the constants header is included where numbers are needed
package watchdog_pkg;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic halt_instr;
    logic sleep_idle;
  } cpu_event_t;

  typedef struct packed {
    logic device_reset;
    logic pc_sp_clear;
    logic ports_preset;
  } reset_req_t;

  typedef struct packed {
    logic integrity_key_reset_flag;
    logic lowvolt_reset_flag;
    logic level_select_reset_flag;
    logic watchdog_key_reset_flag;
  } cause_flags_t;

endpackage

// file: delay_qualifier.sv
// Fires one pulse once a condition has held for COUNT clock cycles
// Assumes cond is synchronous; clear restarts the wait
`timescale 1ns/1ns

module delay_qualifier #(
  parameter logic [15:0] COUNT = 16'h0064
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic cond,
  output logic      fire
);

  logic [15:0] cnt_r;
  logic        done_r;
  logic        fire_r;

  // Fires once per assertion; a held condition does not refire
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
      fire_r <= 1'b0;
    end else if (clear || !cond) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
      fire_r <= 1'b0;
    end else if (!done_r && cnt_r == 16'(COUNT - 16'h0001)) begin
      done_r <= 1'b1;
      fire_r <= 1'b1;
    end else begin
      cnt_r  <= done_r ? cnt_r : 16'(cnt_r + 16'h0001);
      fire_r <= 1'b0;
    end
  end

  assign fire = fire_r;

endmodule

// file: watchdog_and_reset_control_monitor.sv
// Checker for the watchdog and reset supervision block
// Sees only the top module ports; bound to every instance below
`timescale 1ns/1ns
`include "watchdog_cfg.svh"

module watchdog_and_reset_control_monitor (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic [4:0]               address,
  input wire logic                     read,
  input wire logic                     write,
  input wire logic [31:0]              writedata,
  input wire logic [3:0]               byteenable,
  input wire logic [31:0]              readdata,
  input wire logic                     waitrequest,
  input wire watchdog_pkg::cpu_event_t cpu_event,
  input wire watchdog_pkg::reset_req_t reset_req
);
  import watchdog_pkg::*;

  logic wr_ok;

  // A write lands only at the edge where waitrequest is seen low
  assign wr_ok = write && !waitrequest && byteenable[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  chk_wait_once: assert property ((read || write) && waitrequest
    |=> !waitrequest ##1 waitrequest) else $error("bus answer wrong");
  chk_cause_upper: assert property (
    read && !waitrequest && address == `RESET_CAUSE_OFS
    |-> readdata[31:4] == 28'h0) else $error("cause upper bits set");
  chk_ports_full: assert property (
    reset_req.ports_preset == reset_req.device_reset)
    else $error("port preset without full reset");
  chk_pc_full: assert property (
    reset_req.device_reset |-> reset_req.pc_sp_clear)
    else $error("full reset without pc clear");
  chk_sleep_part: assert property (
    reset_req.pc_sp_clear && !reset_req.device_reset
    |-> $past(cpu_event.sleep_idle)) else $error("partial reset awake");
  chk_full_pulse: assert property (
    reset_req.device_reset |=> !reset_req.device_reset)
    else $error("full reset pulse too long");
  // Early firing would restore the register and leave no later reset
  chk_key_delay: assert property (
    wr_ok && address == `WATCHDOG_CONTROL_OFS
    && !(writedata[7:3] inside {5'h15, 5'h0A})
    |=> ##[95:105] reset_req.device_reset) else $error("bad key no reset");
  chk_integ_delay: assert property (
    wr_ok && address == `INTEGRITY_KEY_OFS
    && !(writedata[7:0] inside {8'h55, 8'hAA})
    |=> ##[95:105] reset_req.device_reset) else $error("integ no reset");
  chk_level_delay: assert property (
    wr_ok && address == `LOWVOLT_CONFIG_OFS
    && !(writedata[7:0] inside {8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0, 8'h66})
    |=> ##[95:105] reset_req.device_reset) else $error("level no reset");

  ////////////////////////////////////////////////////////////////////////
  cov_partial: cover property (reset_req.pc_sp_clear
    && !reset_req.device_reset);
  cov_full: cover property (reset_req.device_reset);
  cov_cause: cover property (read && !waitrequest
    && address == `RESET_CAUSE_OFS && readdata[3:0] != 4'h0);
endmodule

bind watchdog_and_reset_control watchdog_and_reset_control_monitor u_mon (
  .clk, .rst, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .cpu_event, .reset_req
);

// file: watchdog_and_reset_control_bench.sv
// Self-checking bench for the watchdog and reset supervision block
// Drives the register bus, RC clock, supply flag and cpu events itself
`timescale 1ns/1ns
`include "watchdog_cfg.svh"

module watchdog_and_reset_control_bench;
  import watchdog_pkg::*;

  localparam logic [4:0] A_CTL = `WATCHDOG_CONTROL_OFS;
  localparam logic [4:0] A_CAU = `RESET_CAUSE_OFS;
  localparam logic [4:0] A_KEY = `INTEGRITY_KEY_OFS;
  localparam logic [4:0] A_LVL = `LOWVOLT_CONFIG_OFS;
  localparam logic [4:0] A_STA = `RUN_STATUS_OFS;

  logic        clk, rst, read, write, waitrequest, rc, lv;
  logic [4:0]  address, a;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [7:0]  v;
  cpu_event_t  ev;
  reset_req_t  rq;
  int          n_errors, total_checks, n_full, n_part, f0, p0;
  logic [7:0]  por_v [3] = '{8'h53, 8'h55, 8'h66};
  logic [7:0]  flg_v [3] = '{8'h01, 8'h08, 8'h02};
  logic [7:0]  lvl_ok [5] = '{8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};

  watchdog_and_reset_control DUT (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .low_speed_rc_clock(rc),
    .lowvolt_detect(lv), .cpu_event(ev), .reset_req(rq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts seen reset pulses; scenarios compare the change only
  always @(posedge clk) begin
    if (!rst && rq.device_reset) n_full++;
    else if (!rst && rq.pc_sp_clear) n_part++;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic int expo(logic [2:0] s);
    return (s < 3'h4) ? 8 + 2 * s : 11 + s;
  endfunction

  function automatic logic bad(int r, logic [7:0] x);
    if (r == 0) return !(x[7:3] inside {5'h15, 5'h0A});
    if (r == 1) return !(x inside {8'h55, 8'hAA});
    return !(x inside {8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0, 8'h66});
  endfunction

  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [4:0] ad, logic [7:0] d, logic [3:0] be);
    logic ok;
    @(posedge clk);
    address <= ad;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge clk);
      ok = !waitrequest;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (!ok) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rchk(string nm, logic [4:0] ad, logic [31:0] e);
    bus(1'b0, ad, 8'h00, 4'hF);
    chk(nm, rd, e);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  // Random high and low times keep the RC edges off any fixed grid
  task automatic ticks(int n);
    repeat (n) begin
      rc <= 1'b1;
      idle(1 + $urandom % 2);
      rc <= 1'b0;
      idle(1 + $urandom % 2);
    end
  endtask

  task automatic pulse(logic c, logic h);
    @(posedge clk);
    ev.clear_watchdog_instr <= c;
    ev.halt_instr <= h;
    @(posedge clk);
    ev.clear_watchdog_instr <= 1'b0;
    ev.halt_instr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    idle(100000);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hEA568D07));
    {rst, read, write, rc, lv, ev} = {5'b10000, 3'b000};
    {address, writedata, byteenable} = '0;
    idle(4);
    rst <= 1'b0;
    rchk("ctrl_por", A_CTL, 32'h53);
    rchk("key_por", A_KEY, 32'h55);
    rchk("lvl_por", A_LVL, 32'h66);
    rchk("cause_por", A_CAU, 32'h0);
    rchk("status_por", A_STA, 32'h0);
    rchk("unmapped", 5'h14, 32'h0);
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, A_CTL, {5'h0A, s[2:0]}, 4'hF);
      pulse(1'b1, 1'b0);
      f0 = n_full;
      ticks((1 << expo(s[2:0])) - 1);
      idle(5);
      chk("no_early", n_full - f0, 0);
      ticks(1);
      idle(5);
      chk("overflow", n_full - f0, 1);
      rchk("expired", A_STA, 32'h1);
    end
    bus(1'b1, A_CTL, {5'h0A, 3'h0}, 4'hF);
    for (int k = 0; k < 2; k++) begin
      pulse(1'b1, 1'b0);
      f0 = n_full;
      ticks(200);
      pulse(k == 0, k == 1);
      ticks(200);
      idle(5);
      chk("restart", n_full - f0, 0);
    end
    rchk("halted", A_STA, 32'h2);
    bus(1'b1, A_KEY, 8'hAA, 4'hF);
    pulse(1'b1, 1'b0);
    ev.sleep_idle <= 1'b1;
    {f0, p0} = {n_full, n_part};
    ticks(256);
    idle(5);
    chk("sleep_part", n_part - p0, 1);
    lv <= 1'b1;
    idle(150);
    lv <= 1'b0;
    chk("sleep_full", n_full - f0, 0);
    ev.sleep_idle <= 1'b0;
    rchk("sleep_stat", A_STA, 32'h3);
    rchk("sleep_key", A_KEY, 32'hAA);
    bus(1'b1, A_CTL, {5'h15, 3'h0}, 4'hF);
    pulse(1'b1, 1'b0);
    ticks(300);
    idle(130);
    chk("disabled", n_full - f0, 0);
    for (int r = 0; r < 3; r++) begin
      a = (r == 0) ? A_CTL : (r == 1) ? A_KEY : A_LVL;
      do v = 8'($urandom); while (!bad(r, v));
      if (r == 1) begin
        bus(1'b1, a, v, 4'hE);
        rchk("be_ignored", A_KEY, 32'h55);
      end
      f0 = n_full;
      bus(1'b1, a, v, 4'hF);
      idle(130);
      chk("soft_rst", n_full - f0, 1);
      rchk("cause_set", A_CAU, {24'h0, flg_v[r]});
      rchk("restored", a, {24'h0, por_v[r]});
      bus(1'b1, A_CAU, 8'hFF, 4'hF);
      rchk("sticky", A_CAU, {24'h0, flg_v[r]});
      bus(1'b1, A_CAU, 8'h00, 4'hF);
      rchk("cleared", A_CAU, 32'h0);
    end
    f0 = n_full;
    foreach (lvl_ok[i]) begin
      bus(1'b1, A_LVL, lvl_ok[i], 4'hF);
      idle(130);
    end
    chk("lvl_valid", n_full - f0, 0);
    bus(1'b1, A_LVL, 8'h33, 4'hF);
    lv <= 1'b1;
    idle(60);
    lv <= 1'b0;
    idle(5);
    chk("lv_short", n_full - f0, 0);
    lv <= 1'b1;
    idle(130);
    lv <= 1'b0;
    chk("lv_long", n_full - f0, 1);
    rchk("lv_cause", A_CAU, 32'h4);
    rchk("lv_kept", A_LVL, 32'h33);
    wrap_up();
  end
endmodule
